// ===== dsss_pkg.sv
// Constants shared by the spread-spectrum test source and its leaves.
// Assumes a 50 MHz system clock and a separate serial link clock.
// Contract
// - Test mode sends the periodic test pattern instead of payload bits.
// - Test pattern is a 2047-bit maximal sequence from an 11-stage shift register.
// - Each pattern period opens with eleven zeros, then nine ones.
// - Serial payload comes with its own clock, any rate up to 125 MHz.
// - Network payload is taken only from a connection to listening port 1024.
// - Each network byte is sent to the modulator most significant bit first.
// - Reload runs at power-up or on command and ends within 1.2 s.
// - Noise is 16-bit, clipped at 4.5 sigma, period above 2^32 samples.
// - Noise sample rate is twice the chip rate.
// - Noise power and signal power are measured and reported as status.
// - Noise has zero mean and sigma of 128 at reference gain.
// - USB payload enters only on the high-speed USB port, never the development port.
// - A test point marks each pattern start, driven only when enabled.
// - Noise power is 24 bits over three bytes, least significant first.
package dsss_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int RELOAD_MS = 1200;
    localparam int RELOAD_CYC = RELOAD_MS * (CLK_HZ / 1000);
    localparam int PN_BITS = 11;
    localparam logic [10:0] PN_SEED = 11'h7ff;
    localparam logic [10:0] PN_LAST = 11'h7fe;
    localparam logic [10:0] PN_ZERO_END = 11'h00a;
    localparam logic [10:0] PN_ONE_END = 11'h013;
    localparam int PN_TAP_OLD = 0;
    localparam int PN_TAP_MID = 2;
    localparam logic [15:0] DATA_PORT = 16'h0400;
    localparam logic [1:0] SRC_SERIAL = 2'h0;
    localparam logic [1:0] SRC_NET = 2'h1;
    localparam logic [1:0] SRC_USB = 2'h2;
    localparam int NZ_SUM = 7;
    localparam int NZ_STEPS = 56;
    localparam logic [63:0] NZ_SEED = 64'h5a3c_96e1_0f27_b4d8;
    localparam logic signed [10:0] NZ_LIM = 11'sh240;
    localparam logic [15:0] NZ_GAIN_REF = 16'h0100;
    localparam int NZ_GAIN_SHIFT = 8;
    localparam int PWR_LOG2 = 10;
    localparam int PWR_ACC_W = 42;
    localparam int PWR_SHIFT = 16;
endpackage

// ===== prbs_gen.sv
// Periodic 2047-bit test pattern generator.
// Assumes the caller advances it once per bit taken by the modulator.
`timescale 1ns/1ns
module prbs_gen
    import dsss_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic restart_in,
    input wire logic adv_in,
    output logic bit_out,
    output logic start_out
);
    typedef struct packed {
        logic [10:0] cnt;
        logic [PN_BITS-1:0] win;
    } pn_t;
    pn_t st_reg;
    pn_t st_next;

    // Window holds the inverted sequence; seed of all ones yields the zero run
    always_comb begin
        st_next = st_reg;
        if (restart_in) begin
            st_next.cnt = '0;
            st_next.win = PN_SEED;
        end else if (adv_in) begin
            if (st_reg.cnt == PN_LAST) begin
                st_next.cnt = '0;
                st_next.win = PN_SEED;
            end else begin
                st_next.cnt = st_reg.cnt + 11'h001;
                st_next.win = {st_reg.win[PN_TAP_OLD] ^ st_reg.win[PN_TAP_MID],
                               st_reg.win[PN_BITS-1:1]};
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= {11'h000, PN_SEED};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bit_out = ~st_reg.win[PN_TAP_OLD];
    assign start_out = (st_reg.cnt == 11'h000);

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    period_wrap_a: assert property (
        adv_in && !restart_in && st_reg.cnt == PN_LAST |=> start_out && st_reg.win == PN_SEED)
        else $error("pattern did not reseed at period end");
    seed_once_a: assert property (
        !start_out |-> st_reg.win != PN_SEED)
        else $error("pattern repeated before 2047 bits");
    head_zero_a: assert property (
        st_reg.cnt <= PN_ZERO_END |-> !bit_out)
        else $error("pattern head zero run wrong");
    head_ones_a: assert property (
        st_reg.cnt > PN_ZERO_END && st_reg.cnt <= PN_ONE_END |-> bit_out)
        else $error("pattern head one run wrong");
endmodule

// ===== pwr_meter.sv
// Windowed mean-square power meter with a 24-bit result.
// Assumes samples arrive as one-cycle strobes on the system clock.
`timescale 1ns/1ns
module pwr_meter
    import dsss_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic strobe_in,
    input wire logic signed [15:0] sample_in,
    output logic [23:0] power_out
);
    typedef struct packed {
        logic [PWR_LOG2-1:0] cnt;
        logic [PWR_ACC_W-1:0] acc;
        logic [23:0] power;
    } pm_t;
    pm_t st_reg;
    pm_t st_next;
    logic [31:0] sq;
    logic [PWR_ACC_W-1:0] sum;
    logic last;

    always_comb begin
        sq = 32'(sample_in * sample_in);
        sum = st_reg.acc + PWR_ACC_W'(sq);
        last = strobe_in && (st_reg.cnt == '1);
        st_next = st_reg;
        if (clear_in) begin
            st_next.cnt = '0;
            st_next.acc = '0;
        end else if (strobe_in) begin
            st_next.cnt = st_reg.cnt + 1'b1;
            st_next.acc = last ? '0 : sum;
            // Last result stays readable while a new window fills
            if (last) begin
                st_next.power = sum[PWR_SHIFT +: 24];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign power_out = st_reg.power;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    power_hold_a: assert property (
        $changed(power_out) |-> $past(last) && !$past(clear_in))
        else $error("power changed outside a window end");
    power_load_a: assert property (
        last && !clear_in |=> power_out == $past(sum[PWR_SHIFT +: 24]))
        else $error("power result not loaded from window sum");
endmodule

// ===== dsss_test_source.sv
// Payload input, test pattern and noise source ahead of a spread-spectrum modulator.
// Assumes the modulator takes one bit per ready cycle and strobes each chip.
`timescale 1ns/1ns
module dsss_test_source
    import dsss_pkg::*;
#(
    parameter int RELOAD_CYCLES = RELOAD_CYC
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic reload_req_in,
    output logic reload_busy_out,
    input wire logic test_mode_in,
    input wire logic [1:0] src_sel_in,
    input wire logic ser_clk_in,
    input wire logic ser_data_in,
    output logic ser_overrun_out,
    input wire logic net_conn_in,
    input wire logic [15:0] net_port_in,
    input wire logic [7:0] net_byte_in,
    input wire logic net_valid_in,
    output logic net_ready_out,
    output logic net_data_conn_out,
    input wire logic [7:0] usb_byte_in,
    input wire logic usb_valid_in,
    output logic usb_ready_out,
    input wire logic mod_ready_in,
    output logic mod_bit_out,
    output logic mod_valid_out,
    input wire logic tp_enable_in,
    output logic tp_prbs_start_out,
    output logic tp_prbs_start_oe_n_out,
    input wire logic chip_strobe_in,
    input wire logic [15:0] noise_gain_in,
    output logic signed [15:0] noise_out,
    output logic noise_valid_out,
    input wire logic signed [15:0] sig_sample_in,
    input wire logic sig_strobe_in,
    output logic [7:0] sig_pwr_b0_out,
    output logic [7:0] sig_pwr_b1_out,
    output logic [7:0] sig_pwr_b2_out,
    output logic [7:0] noise_pwr_b0_out,
    output logic [7:0] noise_pwr_b1_out,
    output logic [7:0] noise_pwr_b2_out
);
    localparam int RL_W = $clog2(RELOAD_CYCLES + 1);

    typedef enum logic {ST_RELOAD, ST_RUN} rl_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] sh;
        logic [7:0] word;
        logic tog;
    } lk_t;

    typedef struct packed {
        rl_state_t state;
        logic [RL_W-1:0] rl_cnt;
        logic [2:0] sync;
        logic seen;
        logic [7:0] sr;
        logic [3:0] bl;
        logic overrun;
        logic [15:0] cp_cnt;
        logic [15:0] cp_len;
        logic [63:0] nz_lfsr;
        logic signed [15:0] noise;
        logic nz_valid;
    } st_t;

    lk_t lk_reg;
    lk_t lk_next;
    st_t st_reg;
    st_t st_next;

    logic run;
    logic net_ok;
    logic pay_idle;
    logic ser_evt;
    logic take;
    logic prbs_bit;
    logic prbs_start;
    logic [15:0] half;
    logic nz_tick;
    logic [63:0] nz_adv;
    logic signed [10:0] nz_sum;
    logic signed [10:0] nz_sc;
    logic signed [10:0] nz_clip;
    logic signed [27:0] nz_prod;
    logic signed [19:0] nz_sh;
    logic signed [15:0] nz_val;
    logic [23:0] sig_pwr;
    logic [23:0] noise_pwr;

    // 64-stage register gives a period far beyond 2^32 samples
    function automatic logic [63:0] nz_step(input logic [63:0] s);
        logic [63:0] v;
        v = s;
        for (int i = 0; i < NZ_STEPS; i++) begin
            v = {v[62:0], v[63] ^ v[62] ^ v[60] ^ v[59]};
        end
        return v;
    endfunction

    function automatic logic signed [10:0] byte_sum(input logic [63:0] s);
        logic signed [10:0] acc;
        acc = '0;
        for (int k = 0; k < NZ_SUM; k++) begin
            acc = acc + 11'(signed'(s[8*k +: 8]));
        end
        return acc;
    endfunction

    // Link side: one bit per rising edge, bytes formed MSB first
    always_comb begin
        lk_next = lk_reg;
        lk_next.cnt = lk_reg.cnt + 3'h1;
        lk_next.sh = {lk_reg.sh[5:0], ser_data_in};
        if (lk_reg.cnt == 3'h7) begin
            lk_next.word = {lk_reg.sh, ser_data_in};
            lk_next.tog = ~lk_reg.tog;
        end
    end

    // Byte alignment is counted from reset; link clock may stop between bytes
    always_ff @(posedge ser_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    assign run = (st_reg.state == ST_RUN);
    assign net_ok = net_conn_in && (net_port_in == DATA_PORT);
    assign pay_idle = run && !test_mode_in && (st_reg.bl == 4'h0);
    assign ser_evt = (st_reg.sync[1] == st_reg.sync[2]) && (st_reg.sync[2] != st_reg.seen);
    assign take = mod_valid_out && mod_ready_in;
    assign half = {1'b0, st_reg.cp_len[15:1]};
    assign nz_tick = run && (chip_strobe_in ||
                     (half != 16'h0000 && st_reg.cp_cnt + 16'h0001 == half));

    // Sum of seven uniform bytes, scaled by 0.656 toward sigma of 128
    always_comb begin
        nz_adv = nz_step(st_reg.nz_lfsr);
        nz_sum = byte_sum(nz_adv);
        nz_sc = (nz_sum >>> 1) + (nz_sum >>> 3) + (nz_sum >>> 5);
        if (nz_sc > NZ_LIM) begin
            nz_clip = NZ_LIM;
        end else if (nz_sc < -NZ_LIM) begin
            nz_clip = -NZ_LIM;
        end else begin
            nz_clip = nz_sc;
        end
        nz_prod = nz_clip * $signed({1'b0, noise_gain_in});
        nz_sh = 20'(nz_prod >>> NZ_GAIN_SHIFT);
        if (nz_sh > 20'sh0_7fff) begin
            nz_val = 16'sh7fff;
        end else if (nz_sh < 20'shf_8000) begin
            nz_val = 16'sh8000;
        end else begin
            nz_val = nz_sh[15:0];
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[1:0], lk_reg.tog};
        st_next.nz_valid = 1'b0;
        if (ser_evt) begin
            st_next.seen = st_reg.sync[2];
        end
        if (chip_strobe_in) begin
            st_next.cp_cnt = '0;
            st_next.cp_len = st_reg.cp_cnt + 16'h0001;
        end else begin
            st_next.cp_cnt = st_reg.cp_cnt + 16'h0001;
        end
        unique case (st_reg.state)
            ST_RELOAD: begin
                st_next.bl = '0;
                st_next.nz_lfsr = NZ_SEED;
                st_next.noise = '0;
                st_next.rl_cnt = st_reg.rl_cnt + 1'b1;
                if (st_reg.rl_cnt == RL_W'(RELOAD_CYCLES - 1)) begin
                    st_next.state = ST_RUN;
                    st_next.rl_cnt = '0;
                end
            end
            ST_RUN: begin
                if (reload_req_in) begin
                    st_next.state = ST_RELOAD;
                    st_next.overrun = 1'b0;
                end
                if (take && !test_mode_in) begin
                    st_next.sr = {st_reg.sr[6:0], 1'b0};
                    st_next.bl = st_reg.bl - 4'h1;
                end
                // Of the USB ports, only the high-speed port has a payload path
                if (net_valid_in && net_ready_out) begin
                    st_next.sr = net_byte_in;
                    st_next.bl = 4'h8;
                end else if (usb_valid_in && usb_ready_out) begin
                    st_next.sr = usb_byte_in;
                    st_next.bl = 4'h8;
                end else if (ser_evt && src_sel_in == SRC_SERIAL && !test_mode_in) begin
                    if (st_reg.bl == 4'h0) begin
                        st_next.sr = lk_reg.word;
                        st_next.bl = 4'h8;
                    end else begin
                        // Set wins over a reload clear in the same cycle
                        st_next.overrun = 1'b1;
                    end
                end
                if (nz_tick) begin
                    st_next.nz_lfsr = nz_adv;
                    st_next.noise = nz_val;
                    st_next.nz_valid = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '{state: ST_RELOAD, nz_lfsr: NZ_SEED, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Network stalls by back-pressure; the client relies on transport flow control
    assign net_ready_out = pay_idle && src_sel_in == SRC_NET && net_ok;
    assign usb_ready_out = pay_idle && src_sel_in == SRC_USB;
    assign net_data_conn_out = net_ok;
    assign mod_valid_out = run && (test_mode_in || st_reg.bl != 4'h0);
    assign mod_bit_out = test_mode_in ? prbs_bit : st_reg.sr[7];
    assign reload_busy_out = !run;
    assign ser_overrun_out = st_reg.overrun;
    assign noise_out = st_reg.noise;
    assign noise_valid_out = st_reg.nz_valid;
    assign tp_prbs_start_out = prbs_start && test_mode_in;
    assign tp_prbs_start_oe_n_out = !tp_enable_in;
    assign {sig_pwr_b2_out, sig_pwr_b1_out, sig_pwr_b0_out} = sig_pwr;
    assign {noise_pwr_b2_out, noise_pwr_b1_out, noise_pwr_b0_out} = noise_pwr;

    prbs_gen u_prbs (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(!run),
        .adv_in(take && test_mode_in),
        .bit_out(prbs_bit),
        .start_out(prbs_start)
    );

    pwr_meter u_sig_pwr (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(!run),
        .strobe_in(sig_strobe_in && run),
        .sample_in(sig_sample_in),
        .power_out(sig_pwr)
    );

    pwr_meter u_noise_pwr (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(!run),
        .strobe_in(st_reg.nz_valid),
        .sample_in(st_reg.noise),
        .power_out(noise_pwr)
    );

    sequence net_take_s;
        net_valid_in && net_ready_out;
    endsequence

    sequence stay_payload_s;
        !test_mode_in && !reload_req_in;
    endsequence

    ser_count_a: assert property (@(posedge ser_clk_in) disable iff (!rst_n_in)
        1'b1 |=> lk_reg.cnt == 3'($past(lk_reg.cnt) + 3'h1))
        else $error("serial capture skipped or repeated a bit");
    ser_cross_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ser_evt && run && src_sel_in == SRC_SERIAL && !test_mode_in && st_reg.bl == 4'h0
        |=> st_reg.sr == $past(lk_reg.word) && st_reg.bl == 4'h8)
        else $error("serial byte not loaded after crossing");
    test_swap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        test_mode_in |-> !net_ready_out && !usb_ready_out && mod_valid_out == run)
        else $error("payload not replaced in test mode");
    net_listen_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        net_ready_out |-> net_conn_in && net_port_in == DATA_PORT)
        else $error("network bytes taken without data connection");
    msb_first_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        net_take_s ##1 stay_payload_s |-> mod_valid_out && mod_bit_out == $past(net_byte_in[7]))
        else $error("network byte not sent MSB first");
    reload_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $fell(reload_busy_out) |-> $past(st_reg.rl_cnt) == RL_W'(RELOAD_CYCLES - 1))
        else $error("reload length wrong");
    reload_go_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        run && reload_req_in |=> reload_busy_out && !mod_valid_out)
        else $error("reload command not obeyed");
    noise_clip_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        nz_clip <= NZ_LIM && nz_clip >= -NZ_LIM)
        else $error("noise exceeds clip limit");
    noise_rate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        run && chip_strobe_in && !reload_req_in |=> noise_valid_out ##1 !noise_valid_out)
        else $error("noise sample missing on chip strobe");
    noise_ref_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        nz_tick && noise_gain_in == NZ_GAIN_REF |=> noise_out == 16'($past(nz_clip)))
        else $error("reference gain not unity");
    usb_only_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        usb_ready_out |-> src_sel_in == SRC_USB && !net_ready_out)
        else $error("payload accepted from wrong port");
    tp_mark_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        tp_enable_in && test_mode_in && prbs_start |-> tp_prbs_start_out && !tp_prbs_start_oe_n_out)
        else $error("pattern start not marked");

    // A serial byte that lands on a busy serializer is dropped whole, never merged
    sequence ser_busy_s;
        ser_evt && run && src_sel_in == SRC_SERIAL && !test_mode_in && st_reg.bl != 4'h0;
    endsequence

    overrun_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ser_busy_s |=> ser_overrun_out)
        else $error("serial overrun not flagged");
    overrun_clr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        run && reload_req_in && !ser_evt |=> !ser_overrun_out)
        else $error("reload did not clear serial overrun");
    byte_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        net_take_s |=> st_reg.sr == $past(net_byte_in) && st_reg.bl == 4'h8 && !net_ready_out)
        else $error("network byte not loaded whole");
    usb_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        usb_valid_in && usb_ready_out |=> st_reg.sr == $past(usb_byte_in) && st_reg.bl == 4'h8)
        else $error("high-speed port byte not loaded");
    // Stalled modulator must see the same bit until it takes it
    bit_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (mod_valid_out && !mod_ready_in && !test_mode_in) ##1 stay_payload_s
        |-> $stable(mod_bit_out))
        else $error("payload bit moved without a take");
    noise_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        run && !nz_tick |=> $stable(noise_out) && !noise_valid_out)
        else $error("noise sample changed without a tick");
    tp_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !test_mode_in |-> !tp_prbs_start_out)
        else $error("pattern start marked outside test mode");
endmodule

// ===== ser_source.sv
// Model of the upstream serial payload source on the link clock.
// Assumes the receiver captures each bit on the rising link clock edge.
`timescale 1ns/1ns
module ser_source (
    output logic ser_clk_out,
    output logic ser_data_out
);
    initial begin
        ser_clk_out = 1'b0;
        ser_data_out = 1'b0;
    end
    // Clock stands still between bytes, 160 ns period inside a byte
    task automatic send_byte(input logic [7:0] b);
        #37;
        for (int i = 7; i >= 0; i--) begin
            ser_data_out = b[i];
            #80 ser_clk_out = 1'b1;
            #80 ser_clk_out = 1'b0;
        end
        // Released line shows the inverse so a stale bit cannot pass
        ser_data_out = ~ser_data_out;
    endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the spread-spectrum test source.
// Assumes the serial source model and a short reload parameter.
`timescale 1ns/1ns
module tb_top;
    import dsss_pkg::*;
    localparam int RLD = 20;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, reload_req_in = 1'b0, test_mode_in = 1'b1;
    logic [1:0] src_sel_in = 2'h3;
    logic ser_clk_in, ser_data_in, net_conn_in = 1'b0, net_valid_in = 1'b0, usb_valid_in = 1'b0;
    logic [15:0] net_port_in = 16'h0000, noise_gain_in = 16'h0100;
    logic [7:0] net_byte_in = 8'h00, usb_byte_in = 8'h00;
    logic mod_ready_in = 1'b1, tp_enable_in = 1'b1, chip_strobe_in = 1'b0;
    logic signed [15:0] sig_sample_in = 16'sh0100;
    logic reload_busy_out, ser_overrun_out, net_ready_out, net_data_conn_out, usb_ready_out;
    logic mod_bit_out, mod_valid_out, tp_prbs_start_out, tp_prbs_start_oe_n_out, noise_valid_out;
    logic signed [15:0] noise_out;
    logic [7:0] sig_pwr_b0_out, sig_pwr_b1_out, sig_pwr_b2_out;
    logic [7:0] noise_pwr_b0_out, noise_pwr_b1_out, noise_pwr_b2_out;
    int err_count = 0, cmp_count = 0, cyc = 0, nz_n = 0, nz_sum = 0, nz_big = 0;
    logic [0:2099] bits, st;

    dsss_test_source #(.RELOAD_CYCLES(RLD)) u_dsss_test_source (
        .sys_clk_in, .rst_n_in, .reload_req_in, .reload_busy_out, .test_mode_in, .src_sel_in,
        .ser_clk_in, .ser_data_in, .ser_overrun_out, .net_conn_in, .net_port_in, .net_byte_in,
        .net_valid_in, .net_ready_out, .net_data_conn_out, .usb_byte_in, .usb_valid_in,
        .usb_ready_out, .mod_ready_in, .mod_bit_out, .mod_valid_out, .tp_enable_in,
        .tp_prbs_start_out, .tp_prbs_start_oe_n_out, .chip_strobe_in, .noise_gain_in,
        .noise_out, .noise_valid_out, .sig_sample_in, .sig_strobe_in(chip_strobe_in),
        .sig_pwr_b0_out, .sig_pwr_b1_out, .sig_pwr_b2_out, .noise_pwr_b0_out,
        .noise_pwr_b1_out, .noise_pwr_b2_out);
    ser_source u_ser_source (.ser_clk_out(ser_clk_in), .ser_data_out(ser_data_in));

    always #10 sys_clk_in = ~sys_clk_in;

    // Chip strobe every 4 cycles, noise statistics, hang guard
    always @(posedge sys_clk_in) begin
        #2;
        cyc = cyc + 1;
        chip_strobe_in = (cyc % 4 == 0);
        if (noise_valid_out === 1'b1) begin
            nz_n = nz_n + 1;
            nz_sum = nz_sum + int'(noise_out);
            if (noise_out > 576 || noise_out < -576) nz_big = nz_big + 1;
        end
        if (cyc == 20000) begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic step();
        @(posedge sys_clk_in);
        #2;
    endtask

    // Records n bits offered to the modulator, with the period-start marker
    task automatic collect(input int n);
        int k, t;
        k = 0;
        t = 0;
        while (k < n && t < 4 * n + 100) begin
            if (mod_valid_out === 1'b1) begin
                bits[k] = mod_bit_out;
                st[k] = tp_prbs_start_out;
                k++;
            end
            step();
            t++;
        end
        check(k, n);
    endtask

    task automatic wait_idle(output int t);
        t = 0;
        while (reload_busy_out !== 1'b0 && t < 100) begin
            step();
            t++;
        end
    endtask

    task automatic test_reload();
        int t;
        check(reload_busy_out, 1);
        wait_idle(t);
        check(t, RLD);
        reload_req_in = 1'b1;
        step();
        reload_req_in = 1'b0;
        check(reload_busy_out, 1);
        wait_idle(t);
        check(t, RLD);
        $display("test reload done");
    endtask

    task automatic test_pattern();
        logic [19:0] head;
        head = 20'h0_01ff;
        check(tp_prbs_start_oe_n_out, 0);
        collect(2067);
        for (int i = 0; i < 20; i++) begin
            check(bits[i], head[19-i]);
            check(bits[2047+i], head[19-i]);
        end
        check({st[0], st[1], st[2046], st[2047]}, 4'h9);
        tp_enable_in = 1'b0;
        #1;
        check(tp_prbs_start_oe_n_out, 1);
        $display("test pattern done");
    endtask

    task automatic push(input int sel, input logic [7:0] b);
        int t;
        t = 0;
        src_sel_in = sel[1:0];
        if (sel == 1) begin
            net_byte_in = b;
            net_valid_in = 1'b1;
        end else begin
            usb_byte_in = b;
            usb_valid_in = 1'b1;
        end
        while (((sel == 1) ? net_ready_out : usb_ready_out) !== 1'b1 && t < 50) begin
            step();
            t++;
        end
        step();
        net_valid_in = 1'b0;
        usb_valid_in = 1'b0;
        collect(8);
        for (int i = 0; i < 8; i++) check(bits[i], b[7-i]);
    endtask

    task automatic test_bytes();
        int t;
        test_mode_in = 1'b0;
        src_sel_in = 2'h1;
        net_conn_in = 1'b1;
        net_port_in = 16'h0401;
        net_valid_in = 1'b1;
        usb_valid_in = 1'b1;
        repeat (3) step();
        check({net_ready_out, net_data_conn_out, usb_ready_out}, 0);
        net_port_in = 16'h0400;
        push(1, 8'ha5);
        check(net_data_conn_out, 1);
        push(1, 8'h3c);
        push(2, 8'h96);
        src_sel_in = 2'h0;
        step();
        fork
            u_ser_source.send_byte(8'hc3);
            collect(8);
        join
        for (int i = 0; i < 8; i++) check(bits[i], 8'hc3 >> (7 - i) & 1);
        check(ser_overrun_out, 0);
        mod_ready_in = 1'b0;
        u_ser_source.send_byte(8'h5a);
        u_ser_source.send_byte(8'h0f);
        repeat (6) step();
        check(ser_overrun_out, 1);
        reload_req_in = 1'b1;
        step();
        reload_req_in = 1'b0;
        check(ser_overrun_out, 0);
        wait_idle(t);
        check(t, RLD);
        mod_ready_in = 1'b1;
        $display("test bytes done");
    endtask

    task automatic test_noise();
        int n0;
        n0 = nz_n;
        repeat (400) step();
        check(nz_n - n0, 200);
        repeat (4200) step();
        check({sig_pwr_b2_out, sig_pwr_b1_out, sig_pwr_b0_out}, 24'h00_0400);
        n0 = {noise_pwr_b2_out, noise_pwr_b1_out, noise_pwr_b0_out};
        check(n0 > 128 && n0 < 512, 1);
        check(nz_big, 0);
        check(nz_sum / nz_n < 16 && nz_sum / nz_n > -16, 1);
        $display("test noise done");
    endtask

    initial begin
        repeat (6) @(posedge sys_clk_in);
        #2;
        rst_n_in = 1'b1;
        test_reload();
        test_pattern();
        test_bytes();
        test_noise();
        complete_run();
    end
endmodule
